// >>> common/recloser_regs.svh
`ifndef RECLOSER_REGS_SVH
`define RECLOSER_REGS_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_LKO_TIME 8'h04
`define OFS_GREC_TIME 8'h08
`define OFS_SET_SEL 8'h0C
`define OFS_SET_DATA 8'h10
`define OFS_STATUS 8'h14
`define OFS_REASON 8'h18
// Control fields and reset values
`define CTRL_CLOSE_RST 0
`define CTRL_GREC_EN 1
`define CTRL_RST 2'h0
`define TIME_RST 22'h000000
// Setting selector fields
`define SEL_FIELD 2:0
`define SEL_SHOT 6:4
`define SEL_REQ 10:8
`define SEL_GRP 14:12
// Setting field codes
`define FLD_EN 3'h0
`define FLD_ARC 3'h1
`define FLD_START 3'h2
`define FLD_DEAD 3'h3
`define FLD_ACT 3'h4
`define FLD_RECL 3'h5
// Timebase
`define CLK_NS 10
`define TICK_NS 500000
`endif

// >>> common/recloser_pkg.sv
package recloser_pkg;
	localparam int NREQ = 5;
	localparam int NSHOT = 5;
	localparam int NGRP = 8;
	localparam int NSET = NGRP * NREQ * NSHOT;
	typedef logic [21:0] ticks_t;
	// Per group, request and shot settings
	typedef struct packed {
		logic en;
		logic discr;
		ticks_t start;
		ticks_t dead;
		ticks_t act;
		ticks_t recl;
	} shot_set_t;
	// Breaker object signals
	typedef struct packed {
		logic open;
		logic closed;
		logic bad;
		logic cmd_blk;
		logic fail;
		logic tmo;
		logic close_seen;
	} cb_in_t;
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_START = 10'h002,
		ST_OPEN = 10'h004,
		ST_DEAD = 10'h008,
		ST_CLOSE = 10'h010,
		ST_ACT = 10'h020,
		ST_RECL = 10'h040,
		ST_LKO = 10'h080,
		ST_GREC = 10'h100,
		ST_LOCK = 10'h200
	} state_t;
endpackage : recloser_pkg

// >>> rtl/auto_recloser.sv
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "recloser_regs.svh"
module auto_recloser #(
	parameter int TICK_CYC = `TICK_NS / `CLK_NS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [4:0] i_req_start,
	input wire logic [4:0] i_req_trip,
	input wire logic i_critical,
	input wire logic i_block,
	input wire logic i_ar_on,
	input wire logic i_lock,
	input wire logic i_lock_reset,
	input wire logic [2:0] i_group,
	input wire recloser_pkg::cb_in_t i_cb,
	output logic o_open_cmd,
	output logic o_close_cmd,
	output logic o_final_trip,
	output logic o_ready,
	output logic o_inhibit,
	output logic o_locked
);
	//////////////////////////////////////////////////////////////////////
	logic [1:0] ctrl_ff;
	recloser_pkg::ticks_t lko_time_ff;
	recloser_pkg::ticks_t grec_time_ff;
	logic [14:0] sel_ff;
	recloser_pkg::shot_set_t set_mem [recloser_pkg::NSET];
	recloser_pkg::state_t state_ff, nxt_state;
	logic [2:0] shot_ff, nxt_shot;
	logic [2:0] req_ff, nxt_req;
	logic trip_ff, nxt_trip;
	logic lko_recl_ff, nxt_lko_recl;
	logic fresh_ff;
	recloser_pkg::ticks_t timer_ff;
	logic [15:0] tick_cnt_ff;
	logic tick_ff;
	logic req_any_ff;
	logic [7:0] lock_why_ff;
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic open_ff, close_ff, ftrip_ff, ready_ff, inhibit_ff, locked_ff;
	logic req_rise, req_act, expired, inhibit, lock_clear, fin_trip, open_now;
	logic [7:0] inh_why, lock_why;
	logic [2:0] new_idx, first_idx, next_idx;
	logic new_trip, first_found, next_found;
	logic [4:0] en_new, en_cur;
	recloser_pkg::shot_set_t cur;

	// Flat setting index of group, request and shot
	function automatic logic [7:0] set_idx(input logic [2:0] g, input logic [2:0] r,
			input logic [2:0] s);
		set_idx = 8'(g * 25 + r * 5 + s);
	endfunction : set_idx

	//////////////////////////////////////////////////////////////////////
	// Timebase tick
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tick_cnt_ff <= 16'h0000;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (tick_cnt_ff == 16'(TICK_CYC - 1));
			tick_cnt_ff <= (tick_cnt_ff == 16'(TICK_CYC - 1)) ? 16'h0000 : tick_cnt_ff + 16'h0001;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Active group settings and enabled shot search
	assign cur = set_mem[set_idx(i_group, req_ff, shot_ff)];
	genvar gs;
	for (gs = 0; gs < recloser_pkg::NSHOT; gs++) begin : g_en
		assign en_new[gs] = set_mem[set_idx(i_group, new_idx, 3'(gs))].en;
		assign en_cur[gs] = set_mem[set_idx(i_group, req_ff, 3'(gs))].en;
	end

	// Pick lowest new request and next enabled shots
	always_comb begin
		new_idx = 3'h0;
		new_trip = 1'b0;
		first_found = 1'b0;
		first_idx = 3'h0;
		next_found = 1'b0;
		next_idx = 3'h0;
		for (int i = recloser_pkg::NREQ - 1; i >= 0; i--) begin
			if (i_req_start[i] | i_req_trip[i]) begin
				new_idx = 3'(i);
				new_trip = i_req_trip[i];
			end
		end
		for (int i = recloser_pkg::NSHOT - 1; i >= 0; i--) begin
			if (en_new[i]) begin
				first_found = 1'b1;
				first_idx = 3'(i);
			end
			if (en_cur[i] && 3'(i) > shot_ff) begin
				next_found = 1'b1;
				next_idx = 3'(i);
			end
		end
	end

	assign req_rise = (|(i_req_start | i_req_trip)) & ~req_any_ff;
	assign req_act = i_req_start[req_ff] | i_req_trip[req_ff];
	assign expired = ~fresh_ff & (timer_ff == '0);

	// Inhibit and lock causes
	always_comb begin
		inh_why = {1'b0, state_ff == recloser_pkg::ST_LOCK, state_ff == recloser_pkg::ST_GREC,
			i_cb.bad, i_cb.cmd_blk, state_ff == recloser_pkg::ST_LKO, ~i_ar_on, i_block};
		lock_why = 8'h00;
		lock_why[0] = i_lock;
		lock_why[2] = i_cb.fail;
		lock_why[3] = i_cb.tmo;
		lock_why[6] = i_critical && state_ff != recloser_pkg::ST_IDLE
			&& state_ff != recloser_pkg::ST_LOCK;
	end
	assign inhibit = |inh_why;
	assign lock_clear = ctrl_ff[`CTRL_CLOSE_RST] ? i_cb.close_seen : i_lock_reset;

	//////////////////////////////////////////////////////////////////////
	// Shot sequencer next state
	always_comb begin
		nxt_state = state_ff;
		nxt_shot = shot_ff;
		nxt_req = req_ff;
		nxt_trip = trip_ff;
		nxt_lko_recl = lko_recl_ff;
		fin_trip = 1'b0;
		open_now = 1'b0;
		case (state_ff)
			recloser_pkg::ST_IDLE: begin
				if (req_rise && !inhibit && first_found) begin
					nxt_req = new_idx;
					nxt_trip = new_trip;
					nxt_shot = first_idx;
					nxt_state = recloser_pkg::ST_START;
				end
			end
			recloser_pkg::ST_START: begin
				if (!fresh_ff && trip_ff && cur.start != '0) begin
					nxt_state = recloser_pkg::ST_IDLE;
				end else if (!fresh_ff && trip_ff) begin
					nxt_state = recloser_pkg::ST_OPEN;
				end else if (!fresh_ff && !req_act) begin
					nxt_state = recloser_pkg::ST_IDLE;
				end else if (expired) begin
					nxt_state = recloser_pkg::ST_OPEN;
				end
			end
			recloser_pkg::ST_OPEN: begin
				if (i_cb.open) begin
					nxt_state = recloser_pkg::ST_DEAD;
				end
			end
			recloser_pkg::ST_DEAD: begin
				if (expired && req_act) begin
					nxt_state = recloser_pkg::ST_LOCK;
				end else if (expired) begin
					nxt_state = recloser_pkg::ST_CLOSE;
				end
			end
			recloser_pkg::ST_CLOSE: begin
				if (i_cb.closed) begin
					nxt_state = (cur.act != '0) ? recloser_pkg::ST_ACT : recloser_pkg::ST_RECL;
				end
			end
			recloser_pkg::ST_ACT: begin
				if (req_rise) begin
					nxt_lko_recl = 1'b1;
					nxt_state = recloser_pkg::ST_LKO;
				end else if (expired) begin
					nxt_state = recloser_pkg::ST_RECL;
				end
			end
			recloser_pkg::ST_RECL: begin
				if (req_rise && next_found) begin
					nxt_shot = next_idx;
					nxt_state = recloser_pkg::ST_START;
				end else if (req_rise) begin
					fin_trip = 1'b1;
					nxt_state = recloser_pkg::ST_LOCK;
				end else if (expired && lko_time_ff != '0) begin
					nxt_lko_recl = 1'b0;
					nxt_state = recloser_pkg::ST_LKO;
				end else if (expired) begin
					nxt_state = ctrl_ff[`CTRL_GREC_EN] ? recloser_pkg::ST_GREC
						: recloser_pkg::ST_IDLE;
				end
			end
			recloser_pkg::ST_LKO: begin
				if (req_rise && !lko_recl_ff) begin
					open_now = 1'b1;
					nxt_state = recloser_pkg::ST_LOCK;
				end else if (expired) begin
					nxt_state = ctrl_ff[`CTRL_GREC_EN] ? recloser_pkg::ST_GREC
						: recloser_pkg::ST_IDLE;
				end
			end
			recloser_pkg::ST_GREC: begin
				if (req_rise) begin
					nxt_state = recloser_pkg::ST_LOCK;
				end else if (expired) begin
					nxt_state = recloser_pkg::ST_IDLE;
				end
			end
			recloser_pkg::ST_LOCK: begin
				if (lock_clear && lock_why == 8'h00) begin
					nxt_state = recloser_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = recloser_pkg::ST_IDLE;
			end
		endcase
		if (lock_why != 8'h00) begin
			nxt_state = recloser_pkg::ST_LOCK;
		end
	end

	// Sequencer registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= recloser_pkg::ST_IDLE;
			shot_ff <= 3'h0;
			req_ff <= 3'h0;
			trip_ff <= 1'b0;
			lko_recl_ff <= 1'b0;
			fresh_ff <= 1'b0;
			req_any_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			shot_ff <= nxt_shot;
			req_ff <= nxt_req;
			trip_ff <= nxt_trip;
			lko_recl_ff <= nxt_lko_recl;
			fresh_ff <= (nxt_state != state_ff) || (nxt_shot != shot_ff);
			req_any_ff <= |(i_req_start | i_req_trip);
		end
	end

	// Phase timer loaded on entry, counts down per tick
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			timer_ff <= `TIME_RST;
		end else if (fresh_ff) begin
			case (state_ff)
				recloser_pkg::ST_START: timer_ff <= cur.start;
				recloser_pkg::ST_DEAD: timer_ff <= cur.dead;
				recloser_pkg::ST_ACT: timer_ff <= cur.act;
				recloser_pkg::ST_RECL: timer_ff <= cur.recl;
				recloser_pkg::ST_LKO: timer_ff <= lko_recl_ff ? cur.recl : lko_time_ff;
				recloser_pkg::ST_GREC: timer_ff <= grec_time_ff;
				default: timer_ff <= `TIME_RST;
			endcase
		end else if (tick_ff && timer_ff != '0) begin
			timer_ff <= timer_ff - 22'h000001;
		end
	end

	// Lock reasons held while locked
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lock_why_ff <= 8'h00;
		end else if (nxt_state == recloser_pkg::ST_LOCK) begin
			lock_why_ff <= lock_why_ff | lock_why | {2'h0, state_ff == recloser_pkg::ST_DEAD,
				state_ff == recloser_pkg::ST_GREC, 2'h0, fin_trip, 1'b0} | {open_now, 7'h00};
		end else begin
			lock_why_ff <= 8'h00;
		end
	end

	// Breaker commands and status outputs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			open_ff <= 1'b0;
			close_ff <= 1'b0;
			ftrip_ff <= 1'b0;
			ready_ff <= 1'b0;
			inhibit_ff <= 1'b0;
			locked_ff <= 1'b0;
		end else begin
			open_ff <= (nxt_state == recloser_pkg::ST_OPEN) | fin_trip | open_now;
			close_ff <= (nxt_state == recloser_pkg::ST_CLOSE);
			ftrip_ff <= fin_trip;
			ready_ff <= ~inhibit;
			inhibit_ff <= inhibit;
			locked_ff <= (nxt_state == recloser_pkg::ST_LOCK);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, writes land at the ack edge
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h00000000;
		end else begin
			ack_ff <= i_wb_cyc & i_wb_stb & ~ack_ff;
			case (i_wb_adr)
				`OFS_CTRL: rdat_ff <= {30'h0, ctrl_ff};
				`OFS_LKO_TIME: rdat_ff <= {10'h000, lko_time_ff};
				`OFS_GREC_TIME: rdat_ff <= {10'h000, grec_time_ff};
				`OFS_SET_SEL: rdat_ff <= {17'h00000, sel_ff};
				`OFS_STATUS: rdat_ff <= {timer_ff[15:0], cur.discr, trip_ff, req_ff,
					shot_ff, locked_ff, ready_ff};
				`OFS_REASON: rdat_ff <= {16'h0000, lock_why_ff, inh_why};
				default: rdat_ff <= 32'h00000000;
			endcase
		end
	end

	// Software written control and time registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_ff <= `CTRL_RST;
			lko_time_ff <= `TIME_RST;
			grec_time_ff <= `TIME_RST;
			sel_ff <= 15'h0000;
		end else if (i_wb_cyc && i_wb_stb && i_wb_we && ack_ff && i_wb_sel == 4'hF) begin
			case (i_wb_adr)
				`OFS_CTRL: ctrl_ff <= i_wb_dat[1:0];
				`OFS_LKO_TIME: lko_time_ff <= i_wb_dat[21:0];
				`OFS_GREC_TIME: grec_time_ff <= i_wb_dat[21:0];
				`OFS_SET_SEL: sel_ff <= i_wb_dat[14:0];
				default: ;
			endcase
		end
	end

	// Shot setting store, one entry per group, request and shot
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < recloser_pkg::NSET; i++) begin
				set_mem[i] <= '0;
			end
		end else if (i_wb_cyc && i_wb_stb && i_wb_we && ack_ff && i_wb_sel == 4'hF
				&& i_wb_adr == `OFS_SET_DATA && sel_ff[`SEL_REQ] < 3'h5
				&& sel_ff[`SEL_SHOT] < 3'h5) begin
			case (sel_ff[`SEL_FIELD])
				`FLD_EN: set_mem[set_idx(sel_ff[`SEL_GRP], sel_ff[`SEL_REQ],
					sel_ff[`SEL_SHOT])].en <= i_wb_dat[0];
				`FLD_ARC: set_mem[set_idx(sel_ff[`SEL_GRP], sel_ff[`SEL_REQ],
					sel_ff[`SEL_SHOT])].discr <= i_wb_dat[0];
				`FLD_START: set_mem[set_idx(sel_ff[`SEL_GRP], sel_ff[`SEL_REQ],
					sel_ff[`SEL_SHOT])].start <= i_wb_dat[21:0];
				`FLD_DEAD: set_mem[set_idx(sel_ff[`SEL_GRP], sel_ff[`SEL_REQ],
					sel_ff[`SEL_SHOT])].dead <= i_wb_dat[21:0];
				`FLD_ACT: set_mem[set_idx(sel_ff[`SEL_GRP], sel_ff[`SEL_REQ],
					sel_ff[`SEL_SHOT])].act <= i_wb_dat[21:0];
				`FLD_RECL: set_mem[set_idx(sel_ff[`SEL_GRP], sel_ff[`SEL_REQ],
					sel_ff[`SEL_SHOT])].recl <= i_wb_dat[21:0];
				default: ;
			endcase
		end
	end

	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;
	assign o_open_cmd = open_ff;
	assign o_close_cmd = close_ff;
	assign o_final_trip = ftrip_ff;
	assign o_ready = ready_ff;
	assign o_inhibit = inhibit_ff;
	assign o_locked = locked_ff;

	//////////////////////////////////////////////////////////////////////
	// Checks
	chk_trip_refuse: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_ff == recloser_pkg::ST_START && !fresh_ff && trip_ff && cur.start != '0
		&& lock_why == 8'h00) |=> state_ff == recloser_pkg::ST_IDLE)
		else $error("trip start not refused");
	chk_dead_entry: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_ff == recloser_pkg::ST_OPEN && i_cb.open && lock_why == 8'h00)
		|=> state_ff == recloser_pkg::ST_DEAD ##1 timer_ff == $past(cur.dead))
		else $error("dead time not started");
	chk_act_closed: assert property (@(posedge i_clk) disable iff (i_rst)
		state_ff == recloser_pkg::ST_ACT |=> !o_open_cmd || o_locked)
		else $error("open during action");
	chk_act_lockout: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_ff == recloser_pkg::ST_ACT && req_rise && lock_why == 8'h00)
		|=> state_ff == recloser_pkg::ST_LKO && lko_recl_ff)
		else $error("no lockout on action request");
	chk_zero_act: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_ff == recloser_pkg::ST_CLOSE && i_cb.closed && cur.act == '0
		&& lock_why == 8'h00) |=> state_ff == recloser_pkg::ST_RECL)
		else $error("zero action not skipped");
	chk_final_lock: assert property (@(posedge i_clk) disable iff (i_rst)
		o_final_trip |-> o_locked && o_open_cmd && lock_why_ff[1])
		else $error("final trip without lock");
	chk_lock_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(state_ff == recloser_pkg::ST_LOCK && !lock_clear) |=> o_locked)
		else $error("lock left without reset");
	chk_block_inh: assert property (@(posedge i_clk) disable iff (i_rst)
		i_block |=> o_inhibit && !o_ready)
		else $error("block did not inhibit");
	chk_lock_why: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_locked) |-> lock_why_ff != 8'h00)
		else $error("lock without reason");
endmodule : auto_recloser

// >>> sim/breaker_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Breaker object: follows open and close commands after a travel delay
module breaker_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_open_cmd,
	input wire logic i_close_cmd,
	input wire logic i_slow,
	input wire logic i_fail,
	output recloser_pkg::cb_in_t o_cb
);
	logic [3:0] wait_ff;
	recloser_pkg::cb_in_t cb_ff;
	assign o_cb = cb_ff;
	// Starts closed; contacts move once the travel delay has run
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cb_ff <= '{closed: 1'b1, default: 1'b0};
			wait_ff <= 4'h0;
		end else begin
			cb_ff.fail <= i_fail;
			cb_ff.close_seen <= i_close_cmd;
			if ((i_open_cmd && !cb_ff.open) || (i_close_cmd && !cb_ff.closed)) begin
				wait_ff <= wait_ff + 4'h1;
				if (wait_ff >= (i_slow ? 4'h6 : 4'h1)) begin
					cb_ff.open <= i_open_cmd;
					cb_ff.closed <= !i_open_cmd;
					wait_ff <= 4'h0;
				end
			end
		end
	end
endmodule : breaker_model

// >>> sim/auto_recloser_tb.sv
`timescale 1ns/1ps
`include "recloser_regs.svh"
module auto_recloser_tb;
	logic i_clk, i_rst, wb_cyc, wb_stb, wb_we, o_wb_ack, hit;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat, o_wb_dat, rd;
	logic [4:0] req_start, req_trip;
	logic critical, blk, ar_on, lock, lock_reset, slow, fail;
	logic [2:0] group;
	recloser_pkg::cb_in_t cb;
	logic open_cmd, close_cmd, final_trip, ready, inhibit, locked;
	int num_errors = 0;
	int comparisons = 0;
	int n;
	////////////////////////////////////////////////////////////////
	auto_recloser #(.TICK_CYC(4)) u_dut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_wb_cyc(wb_cyc),
		.i_wb_stb(wb_stb),
		.i_wb_we(wb_we),
		.i_wb_adr(wb_adr),
		.i_wb_sel(wb_sel),
		.i_wb_dat(wb_dat),
		.o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack),
		.i_req_start(req_start),
		.i_req_trip(req_trip),
		.i_critical(critical),
		.i_block(blk),
		.i_ar_on(ar_on),
		.i_lock(lock),
		.i_lock_reset(lock_reset),
		.i_group(group),
		.i_cb(cb),
		.o_open_cmd(open_cmd),
		.o_close_cmd(close_cmd),
		.o_final_trip(final_trip),
		.o_ready(ready),
		.o_inhibit(inhibit),
		.o_locked(locked)
	);
	breaker_model u_cb (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_open_cmd(open_cmd),
		.i_close_cmd(close_cmd),
		.i_slow(slow),
		.i_fail(fail),
		.o_cb(cb)
	);
	////////////////////////////////////////////////////////////////
	// Clock at 100 MHz
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One classic bus cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= d;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (o_wb_ack !== 1'b1 && k < 50);
		check(o_wb_ack, 32'h1);
		rd = o_wb_dat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	task set(input int g, r, s, f, input logic [31:0] v);
		wb(1'b1, `OFS_SET_SEL, 32'(g * 4096 + r * 256 + s * 16 + f));
		wb(1'b1, `OFS_SET_DATA, v);
	endtask : set
	// Bounded wait on an output: 0 open, 1 close, 2 final trip, 3 locked
	task waitfor(input int w, input int lim);
		n = 0;
		hit = 1'b0;
		while (hit !== 1'b1 && n < lim) begin
			@(posedge i_clk);
			n++;
			case (w)
				0: hit = open_cmd;
				1: hit = close_cmd;
				2: hit = final_trip;
				default: hit = locked;
			endcase
		end
	endtask : waitfor
	task clear_lock;
		repeat (20) @(posedge i_clk);
		check(locked, 1'b1);
		lock_reset <= 1'b1;
		@(posedge i_clk);
		lock_reset <= 1'b0;
		repeat (3) @(posedge i_clk);
		check(locked, 1'b0);
	endtask : clear_lock
	task end_of_test;
		$display("Errors %0d, comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test
	// Watchdog
	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		end_of_test;
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{i_rst, ar_on} = 2'b11;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
		wb_sel = 4'hF;
		{req_start, req_trip, group} = '0;
		{critical, blk, lock, lock_reset, slow, fail} = '0;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_clk);
		check(ready, 1'b1);
		wb(1'b0, `OFS_CTRL, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, 8'h1C, 32'h0);
		check(rd, 32'h0);
		// Shots only in group 1; group 0 request has none
		set(1, 4, 0, 0, 32'h1);
		set(1, 4, 0, 3, 32'h2);
		req_trip <= 5'h10;
		waitfor(0, 30);
		check(hit, 1'b0);
		req_trip <= 5'h00;
		group <= 3'h1;
		@(posedge i_clk);
		req_trip <= 5'h10;
		waitfor(0, 30);
		check(hit, 1'b1);
		req_trip <= 5'h00;
		waitfor(1, 100);
		check(hit, 1'b1);
		repeat (20) @(posedge i_clk);
		group <= 3'h0;
		// Inhibit inputs and reasons
		blk <= 1'b1;
		repeat (3) @(posedge i_clk);
		check({ready, inhibit}, 2'b01);
		wb(1'b0, `OFS_REASON, 32'h0);
		check(rd[0], 1'b1);
		{blk, ar_on} <= 2'b00;
		repeat (3) @(posedge i_clk);
		check(inhibit, 1'b1);
		ar_on <= 1'b1;
		repeat (3) @(posedge i_clk);
		check(ready, 1'b1);
		// Locking input, then breaker failure
		lock <= 1'b1;
		waitfor(3, 6);
		check(hit, 1'b1);
		wb(1'b0, `OFS_REASON, 32'h0);
		check({rd[8], rd[6]}, 2'b11);
		lock <= 1'b0;
		clear_lock;
		fail <= 1'b1;
		waitfor(3, 6);
		check(hit, 1'b1);
		fail <= 1'b0;
		clear_lock;
		// Disabled first shot skipped, dead time then reclaim
		set(0, 0, 1, 0, 32'h1);
		set(0, 0, 1, 3, 32'd10);
		set(0, 0, 1, 5, 32'd20);
		req_trip <= 5'h01;
		waitfor(0, 20);
		check(hit, 1'b1);
		req_trip <= 5'h00;
		wb(1'b0, `OFS_STATUS, 32'h0);
		check(rd[4:2], 3'h1);
		waitfor(1, 200);
		check(n >= 36 && n <= 52, 1'b1);
		repeat (8) @(posedge i_clk);
		req_trip <= 5'h01;
		waitfor(2, 20);
		check(hit, 1'b1);
		req_trip <= 5'h00;
		clear_lock;
		// Trip request refused with nonzero start; start request timed
		set(0, 1, 0, 0, 32'h1);
		set(0, 1, 0, 2, 32'h3);
		set(0, 1, 0, 3, 32'h1);
		slow <= 1'b1;
		req_trip <= 5'h02;
		waitfor(0, 30);
		check(hit, 1'b0);
		req_trip <= 5'h00;
		@(posedge i_clk);
		req_start <= 5'h02;
		repeat (4) @(posedge i_clk);
		req_start <= 5'h00;
		waitfor(0, 30);
		check(hit, 1'b0);
		req_start <= 5'h02;
		waitfor(0, 40);
		check(n >= 12 && n <= 18, 1'b1);
		req_start <= 5'h00;
		waitfor(1, 100);
		check(hit, 1'b1);
		repeat (20) @(posedge i_clk);
		// Critical request in mid-cycle
		req_trip <= 5'h01;
		waitfor(0, 20);
		{req_trip, critical} <= {5'h00, 1'b1};
		waitfor(3, 10);
		check(hit, 1'b1);
		critical <= 1'b0;
		clear_lock;
		// Request during action time locks out for reclaim time
		set(0, 2, 0, 0, 32'h1);
		set(0, 2, 0, 4, 32'h5);
		set(0, 2, 0, 5, 32'h5);
		slow <= 1'b0;
		req_trip <= 5'h04;
		waitfor(0, 20);
		check(hit, 1'b1);
		req_trip <= 5'h00;
		waitfor(1, 40);
		check(hit, 1'b1);
		repeat (6) @(posedge i_clk);
		req_trip <= 5'h04;
		@(posedge i_clk);
		req_trip <= 5'h00;
		repeat (3) @(posedge i_clk);
		check({inhibit, locked, open_cmd}, 3'b100);
		repeat (40) @(posedge i_clk);
		check(ready, 1'b1);
		end_of_test;
	end
endmodule : auto_recloser_tb
